// ---- hdl/iocig_buf2.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Two-entry skid buffer with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Outputs come straight from flip-flops; in_ready_o is registered
//////////////////////////////////////////////////////////////////////////////
module iocig_buf2 #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);

    logic             skid_valid;
    logic [WIDTH-1:0] skid_data;

    // Handshake terms
    wire take    = in_valid_i & in_ready_o;
    wire drain   = out_valid_o & out_ready_i;
    wire out_free = ~out_valid_o | drain;

    assign in_ready_o = ~skid_valid;

    // Output stage refills from skid first so order is kept
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
            skid_valid  <= 1'b0;
            skid_data   <= '0;
        end else begin
            if (out_free) begin
                if (skid_valid) begin
                    out_valid_o <= 1'b1;
                    out_data_o  <= skid_data;
                    skid_valid  <= take;
                    skid_data   <= in_data_i;
                end else begin
                    out_valid_o <= take;
                    out_data_o  <= in_data_i;
                end
            end else if (take) begin
                skid_valid <= 1'b1;   // Receiver stalled: park the word
                skid_data  <= in_data_i;
            end
        end
    end

endmodule : iocig_buf2

// ---- hdl/iocig_cell_pair.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: I/O cell pair: output drive and input capture for two slices
// Assumes: 50 MHz clock_i samples all link signals through two flip-flops
// Notes:   Link clocks are found by edge detection, not used as clocks
//////////////////////////////////////////////////////////////////////////////
//
// Chosen here: the register offsets and the APB slave port.
module iocig_cell_pair
    import iocig_pkg::*;
#(
    parameter bit EDGE_SIDE = 1'b1   // Gearbox only exists on left/right edges
) (
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    // APB slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [7:0]             paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // Core side of the output path and the input delay tap select
    input  wire logic [1:0]             core_out_data_i,
    input  wire logic [1:0]             core_tristate_i,
    input  wire logic [3:0]             delay_select_i,
    // Pad buffers
    input  wire logic [1:0]             pad_in_data_i,
    output logic      [1:0]             pad_out_data_o,
    output logic      [1:0]             pad_tristate_ctl_o,
    // Link signals from the strobe read control
    input  wire logic                   strobe_read_clk_i,
    input  wire logic                   edge_clk_i,
    input  wire logic                   sync_clk_polarity_i,
    input  wire logic                   sync_transfer_latch_i,
    // Bypass paths
    output logic      [1:0]             comb_in_path_o,
    output logic      [1:0]             clk_in_path_o,
    output logic                        strobe_delay_in_o,
    // Captured stream to the core
    output logic                        rx_valid_o,
    output iocig_pkg::iocig_word_t      rx_data_o,
    input  wire logic                   rx_ready_i
);

    //////////////////////////////////////////////////////////////////////////
    // Capture sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARM  = 3'b010,
        ST_RUN  = 3'b100
    } iocig_state_t;

    iocig_state_t state;
    iocig_state_t next_state;

    // Picks one tap of a delay line
    function automatic logic tap_pick(input logic [DLY_TAPS-1:0] line, input logic [3:0] sel);
        tap_pick = line[sel];
    endfunction : tap_pick

    //////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; stage one is read only by stage two
    logic [5:0] sync1;
    logic [5:0] sync2;
    wire  [5:0] raw_in = {sync_transfer_latch_i, sync_clk_polarity_i, edge_clk_i,
                          strobe_read_clk_i, pad_in_data_i};

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end

    wire [1:0] pad_s   = sync2[1:0];
    wire       strb_s  = sync2[2];
    wire       edge_clk_s  = sync2[3];
    wire       pol_s   = sync2[4];
    wire       latch_s = sync2[5];

    //////////////////////////////////////////////////////////////////////////
    // Control register; mode and delay fields are frozen while enabled
    logic [CTRL_WIDTH-1:0] ctrl;
    logic                  ovf;

    wire         cap_en   = ctrl[CTRL_EN_BIT];
    iocig_mode_t mode_raw;
    iocig_mode_t mode;
    assign mode_raw = iocig_mode_t'(ctrl[CTRL_MODE_LO +: 2]);
    assign mode     = (mode_raw == IOCIG_GEAR && !EDGE_SIDE) ? IOCIG_DDR : mode_raw;
    wire         mem_md   = ctrl[CTRL_MEM_BIT];
    wire         dly_dyn  = ctrl[CTRL_DDYN_BIT];
    wire         dly_en   = ctrl[CTRL_DEN_BIT];

    // APB decode
    wire setup    = psel_i & ~penable_i;
    wire wr_acc   = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = (paddr_i == ADDR_CTRL);
    wire hit_stat = (paddr_i == ADDR_STATUS);
    wire hit_data = (paddr_i == ADDR_DATA);
    wire mapped   = hit_ctrl | hit_stat | hit_data;

    //////////////////////////////////////////////////////////////////////////
    // Pad delay lines, one per slice
    logic [DLY_TAPS-1:0] dly_line [2];
    logic [1:0]          pad_tap;

    wire [3:0] tap_sel = dly_dyn ? delay_select_i : DLY_FIXED;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dly_line[0] <= '0;
            dly_line[1] <= '0;
        end else begin
            dly_line[0] <= {dly_line[0][DLY_TAPS-2:0], pad_s[0]};
            dly_line[1] <= {dly_line[1][DLY_TAPS-2:0], pad_s[1]};
        end
    end

    // Delay is optional: tap zero bypasses nothing but still needs a cycle
    assign pad_tap[0] = dly_en ? tap_pick(dly_line[0], tap_sel) : pad_s[0];
    assign pad_tap[1] = dly_en ? tap_pick(dly_line[1], tap_sel) : pad_s[1];

    //////////////////////////////////////////////////////////////////////////
    // Sampling clock edges: read strobe in memory mode, edge clock otherwise
    logic smp_q;
    wire  smp_now  = mem_md ? strb_s : edge_clk_s;
    wire  smp_rise = smp_now & ~smp_q;
    wire  smp_fall = ~smp_now & smp_q;
    wire  load_ev  = pol_s ? smp_rise : smp_fall;

    logic [1:0] pos_q;
    logic [1:0] neg_q;
    logic [1:0] sync_pos;
    logic [1:0] sync_neg;
    logic [1:0] gear_pos_a;
    logic [1:0] gear_neg_a;
    logic       gear_phase;

    // Pair handed to the sync stage depends on which edge loads it
    wire [1:0] pair_pos = pos_q;
    wire [1:0] pair_neg = pol_s ? neg_q : pad_tap;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            smp_q <= 1'b0;
            pos_q <= '0;
            neg_q <= '0;
        end else begin
            smp_q <= smp_now;
            if (smp_rise) begin
                pos_q <= pad_tap;
            end
            if (smp_fall) begin
                neg_q <= pad_tap;
            end
        end
    end

    // Sync registers and first gear pair, loaded on the chosen edge
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sync_pos   <= '0;
            sync_neg   <= '0;
            gear_pos_a <= '0;
            gear_neg_a <= '0;
            gear_phase <= 1'b0;
        end else if (load_ev) begin
            sync_pos   <= pair_pos;
            sync_neg   <= pair_neg;
            gear_pos_a <= sync_pos;
            gear_neg_a <= sync_neg;
            gear_phase <= (state == ST_RUN) ? ~gear_phase : 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer: ARM waits for one sync load, SDR excepted, so the gear phase is aligned
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cap_en) next_state = ST_ARM;
            end
            ST_ARM: begin
                if (!cap_en) next_state = ST_IDLE;
                else if (load_ev || mode == IOCIG_SDR) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!cap_en) next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Transfer into the clock-transfer stage and on to the buffer
    wire running  = (state == ST_RUN);
    wire ddr_push = running & (mode == IOCIG_DDR) & load_ev & latch_s;
    wire gear_push = running & (mode == IOCIG_GEAR) & load_ev & latch_s & gear_phase;
    wire sdr_push = running & (mode == IOCIG_SDR);

    iocig_word_t push_word;
    logic        push_valid;
    logic        buf_ready;
    iocig_word_t next_word;

    // Word layout per mode; sync stage is the newest pair
    always_comb begin
        next_word      = '0;
        next_word.mode = mode;
        unique case (mode)
            IOCIG_SDR: begin
                next_word.s0 = {3'h0, pad_tap[0]};
                next_word.s1 = {1'b0, pad_tap[1]};
            end
            IOCIG_GEAR: begin
                next_word.s0 = {gear_neg_a[0], gear_pos_a[0], sync_neg[0], sync_pos[0]};
                next_word.s1 = {sync_pos[1], sync_neg[1]};
            end
            default: begin
                next_word.s0 = {2'h0, sync_pos[0], sync_neg[0]};
                next_word.s1 = {sync_pos[1], sync_neg[1]};
            end
        endcase
    end

    // One-cycle delayed push so the sync stage is settled when copied
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            push_valid <= 1'b0;
            push_word  <= '0;
        end else if (!push_valid || buf_ready) begin
            push_valid <= ddr_push | gear_push | sdr_push;
            push_word  <= next_word;
        end
    end

    // A word arriving while the buffer is full is dropped and flagged
    wire lost = push_valid & ~buf_ready & (ddr_push | gear_push | sdr_push);

    iocig_buf2 #(
        .WIDTH      (WORD_W)
    ) u_buf (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .in_valid_i (push_valid),
        .in_data_i  (push_word),
        .in_ready_o (buf_ready),
        .out_valid_o(rx_valid_o),
        .out_data_o (rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    //////////////////////////////////////////////////////////////////////////
    // Output path and bypass paths, registered per slice
    wire bypass = (mode == IOCIG_BYPASS);

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pad_out_data_o     <= '0;
            pad_tristate_ctl_o <= 2'h3;   // Released until the core drives
            comb_in_path_o     <= '0;
            clk_in_path_o      <= '0;
            strobe_delay_in_o  <= 1'b0;
        end else begin
            pad_out_data_o     <= core_out_data_i;
            pad_tristate_ctl_o <= core_tristate_i;
            comb_in_path_o     <= bypass ? pad_tap : 2'h0;
            clk_in_path_o      <= bypass ? pad_s : 2'h0;
            strobe_delay_in_o  <= bypass & pad_s[0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Registers: ctrl write, overflow write-one-clear, set wins over clear
    wire ovf_clr = wr_acc & hit_stat & pwdata_i[STAT_OVF_BIT];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            ovf  <= 1'b0;
        end else begin
            if (wr_acc && hit_ctrl) begin
                ctrl[CTRL_EN_BIT] <= pwdata_i[CTRL_EN_BIT];
                if (!cap_en) begin
                    ctrl[CTRL_WIDTH-1:1] <= pwdata_i[CTRL_WIDTH-1:1];
                end
            end
            if (lost) begin
                ovf <= 1'b1;
            end else if (ovf_clr) begin
                ovf <= 1'b0;
            end
        end
    end

    // Read data assembled at setup so it is registered for the access phase
    wire [31:0] rd_ctrl = {{(32 - CTRL_WIDTH){1'b0}}, ctrl};
    wire [31:0] rd_stat = {27'h0, state, rx_valid_o, ovf};
    wire [31:0] rd_data = {24'h0, rx_data_o};
    wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl : hit_stat ? rd_stat : hit_data ? rd_data : 32'h0;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup;
            if (setup) begin
                prdata_o  <= rd_mux;
                pslverr_o <= ~mapped;
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

endmodule : iocig_cell_pair

// ---- hdl/iocig_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the I/O cell pair input capture
// Assumes: One 50 MHz system clock, APB register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
//////////////////////////////////////////////////////////////////////////////
package iocig_pkg;

    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_DATA     = 8'h08;

    // Control register field positions
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_MODE_LO  = 1;
    localparam int unsigned CTRL_MEM_BIT  = 3;
    localparam int unsigned CTRL_DDYN_BIT = 4;
    localparam int unsigned CTRL_DEN_BIT  = 5;
    localparam int unsigned CTRL_WIDTH    = 6;
    localparam logic [5:0]  CTRL_RESET    = 6'h00;

    // Status register field positions
    localparam int unsigned STAT_OVF_BIT  = 0;
    localparam int unsigned STAT_VLD_BIT  = 1;
    localparam int unsigned STAT_ST_LO    = 2;

    // Delay line
    localparam int unsigned DLY_TAPS      = 16;
    localparam logic [3:0]  DLY_FIXED     = 4'h4;

    // Input capture modes
    typedef enum logic [1:0] {
        IOCIG_BYPASS = 2'h0,
        IOCIG_SDR    = 2'h1,
        IOCIG_DDR    = 2'h2,
        IOCIG_GEAR   = 2'h3
    } iocig_mode_t;

    // Word handed to the core
    typedef struct packed {
        iocig_mode_t mode;
        logic [1:0]  s1;   // Second slice {pos, neg}, SDR in bit 0
        logic [3:0]  s0;   // First slice, gear {neg_a, pos_a, neg_b, pos_b}
    } iocig_word_t;

    localparam int unsigned WORD_W        = 8;

endpackage : iocig_pkg

// ---- tb/iocig_cell_pair_tb.sv ----
////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the I/O cell pair
// Assumes: 50 MHz clock, DDR source model on the pads
// Notes:   Register rows, capture frames, stall, bypass, reset
////////////////////////////////////////////////////////////
module iocig_cell_pair_tb
    import iocig_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } iocig_row_t;

    logic            clock_i, rst_i, psel, penable, pwrite, pready, pslverr, rx_ready, rx_valid, err;
    logic            pol, use_strobe, run, latch_en, link_clk, latch, strobe_dly, watch, byp;
    logic [7:0]      paddr, exp_w, msk_w;
    logic [31:0]     pwdata, prdata, rd;
    logic [1:0]      core_out, core_tri, pad_in, pad_out, pad_tri, comb, clkp, pos, neg;
    logic [3:0]      dsel;
    logic [7:0][1:0] hist;
    iocig_word_t     rx_data;
    int              err_count, compares, words;

    // Reset values, refused mode change while enabled, unmapped word
    iocig_row_t rows [10] = '{
        '{1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_STATUS, 32'h0, 32'h4, 1'b0},
        '{1'b0, ADDR_DATA, 32'h0, 32'h0, 1'b0}, '{1'b1, ADDR_CTRL, 32'h5, 32'h0, 1'b0},
        '{1'b1, ADDR_CTRL, 32'h3, 32'h0, 1'b0}, '{1'b0, ADDR_CTRL, 32'h0, 32'h5, 1'b0},
        '{1'b1, ADDR_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, ADDR_CTRL, 32'h0, 32'h4, 1'b0},
        '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h0C, 32'h7, 32'h0, 1'b1}};

    iocig_cell_pair dut (
        .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .core_out_data_i(core_out), .core_tristate_i(core_tri), .delay_select_i(dsel),
        .pad_in_data_i(pad_in), .pad_out_data_o(pad_out), .pad_tristate_ctl_o(pad_tri),
        .strobe_read_clk_i(use_strobe & link_clk), .edge_clk_i(~use_strobe & link_clk),
        .sync_clk_polarity_i(pol), .sync_transfer_latch_i(latch), .comb_in_path_o(comb),
        .clk_in_path_o(clkp), .strobe_delay_in_o(strobe_dly), .rx_valid_o(rx_valid),
        .rx_data_o(rx_data), .rx_ready_i(rx_ready));

    iocig_ddr_src u_src (
        .run_i(run), .latch_en_i(latch_en), .pos_i(pos), .neg_i(neg),
        .link_clk_o(link_clk), .pad_o(pad_in), .latch_o(latch));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Core drive keeps changing; taken words and bypass tap checked
    always @(posedge clock_i) begin
        {dsel, core_tri, core_out} <= {dsel, core_tri, core_out} + 8'h1B;
        hist <= {hist[6:0], pad_in};
        if (byp) chk("bypass clock tap", {30'h0, hist[2]}, {30'h0, clkp});
        if (byp) chk("bypass delayed tap", {30'h0, hist[DLY_FIXED + 3]}, {30'h0, comb});
        if (watch && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            words <= words + 1;
            chk("rx word", {24'h0, exp_w & msk_w}, {24'h0, rx_data & msk_w});
        end
    end

    // One APB transfer: request held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            chk("apb ready", 32'h1, 32'h0);
            close_out();
        end
        {psel, penable} <= 2'h0;
        @(posedge clock_i);
    endtask : apb

    // Disable, configure, enable; drain anything left over
    task automatic set_mode(input logic [5:0] cfg);
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (8) @(posedge clock_i);
        apb(1'b1, ADDR_CTRL, {26'h0, cfg & 6'h3E});
        apb(1'b1, ADDR_CTRL, {26'h0, cfg});
    endtask : set_mode

    task automatic frame(input string name, input logic [5:0] cfg, input logic p, s, l,
                         input logic [7:0] e, m);
        set_mode(cfg);
        {pol, use_strobe, latch_en, exp_w, msk_w, watch, words} <= {p, s, l, e, m, 1'b1, 32'h0};
        run <= 1'b1;
        repeat (128) @(posedge clock_i);
        run <= 1'b0;
        repeat (24) @(posedge clock_i);
        watch <= 1'b0;
        chk("words seen", {31'h0, l}, {31'h0, words > 0});
        chk("bypass taps idle", 32'h0, {28'h0, comb, clkp});
        $display("test %s done", name);
    endtask : frame

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge clock_i);
        chk("run time", 32'h0, 32'h1);
        close_out();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, core_out, core_tri, dsel} = '0;
        {pol, use_strobe, run, latch_en, watch, byp, hist, exp_w, msk_w} = '0;
        {rx_ready, rst_i, pos, neg} = 6'h39;
        {err_count, compares, words} = '0;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        chk("tristate after reset", 32'h3, {30'h0, pad_tri});
        @(posedge clock_i);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            chk("apb error", {31'h0, rows[i].err}, {31'h0, err});
            if (!rows[i].wr) chk("apb read", rows[i].rdata, rd);
        end
        $display("test registers done");
        frame("latch low", 6'h05, 1'b0, 1'b0, 1'b0, 8'hA1, 8'hFF);
        frame("ddr strobe pol1", 6'h0D, 1'b1, 1'b1, 1'b1, 8'hA1, 8'hFF);
        frame("gearbox", 6'h07, 1'b0, 1'b0, 1'b1, 8'hCA, 8'hCF);
        frame("sdr", 6'h03, 1'b0, 1'b0, 1'b1, 8'h40, 8'hC0);
        frame("ddr edge pol0", 6'h05, 1'b0, 1'b0, 1'b1, 8'hA1, 8'hFF);
        // Receiver stalls: buffer keeps its words, the rest are dropped
        set_mode(6'h05);
        {rx_ready, run} <= 2'h1;
        repeat (64) @(posedge clock_i);
        run <= 1'b0;
        repeat (24) @(posedge clock_i);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status stalled", 32'h13, rd);
        apb(1'b0, ADDR_DATA, 32'h0);
        chk("data peek", 32'hA1, rd);
        {rx_ready, watch, words} <= {2'h3, 32'h0};
        repeat (8) @(posedge clock_i);
        watch <= 1'b0;
        chk("drained words", 32'h1, {31'h0, words > 0});
        apb(1'b1, ADDR_STATUS, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("overflow cleared", 32'h10, rd);
        $display("test stall done");
        set_mode(6'h21);
        byp <= 1'b1;
        repeat (24) @(posedge clock_i);
        byp <= 1'b0;
        $display("test bypass done");
        // Reset in mid-frame floats the pads and clears the config
        set_mode(6'h05);
        run <= 1'b1;
        repeat (40) @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        chk("tristate in reset", 32'h3, {30'h0, pad_tri});
        @(posedge clock_i);
        {rst_i, run} <= 2'h0;
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk("config after reset", 32'h0, rd);
        $display("test reset done");
        close_out();
    end
endmodule : iocig_cell_pair_tb

// ---- tb/iocig_ddr_src.sv ----
////////////////////////////////////////////////////////////
// Purpose: Behavioural DDR source for pads, strobe and latch
// Assumes: 160 ns link period, phase free of the system clock
// Notes:   Link clock still between frames; pads toggle then
////////////////////////////////////////////////////////////
module iocig_ddr_src (
    input  wire logic       run_i,
    input  wire logic       latch_en_i,
    input  wire logic [1:0] pos_i,
    input  wire logic [1:0] neg_i,
    output logic            link_clk_o,
    output logic [1:0]      pad_o,
    output logic            latch_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Latch only in a frame, so idle pads never reach the DDR or gear stream
    assign latch_o = run_i && latch_en_i;

    // Data leads each strobe edge by 10 ns and holds 70 ns after it
    initial begin
        link_clk_o = 1'b0;
        pad_o = 2'h0;
        #7;
        forever begin
            if (run_i) begin
                pad_o = pos_i;
                #10 link_clk_o = 1'b1;
                #70 pad_o = neg_i;
                #10 link_clk_o = 1'b0;
                #70;
            end else begin
                pad_o = ~pad_o; // Released pads must not look held
                #20;
            end
        end
    end
endmodule : iocig_ddr_src

// ---- tb/iocig_monitor.sv ----
////////////////////////////////////////////////////////////
// Purpose: Port-level checks of the I/O cell pair
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Sees top-level ports only; bound to every instance
////////////////////////////////////////////////////////////
module iocig_monitor
    import iocig_pkg::*;
(
    input wire logic                  clock_i,
    input wire logic                  rst_i,
    input wire logic                  psel_i,
    input wire logic                  penable_i,
    input wire logic [7:0]            paddr_i,
    input wire logic                  pready_o,
    input wire logic                  pslverr_o,
    input wire logic [1:0]            core_out_data_i,
    input wire logic [1:0]            core_tristate_i,
    input wire logic [1:0]            pad_out_data_o,
    input wire logic [1:0]            pad_tristate_ctl_o,
    input wire logic [1:0]            clk_in_path_o,
    input wire logic                  strobe_delay_in_o,
    input wire logic                  rx_valid_o,
    input wire iocig_pkg::iocig_word_t rx_data_o,
    input wire logic                  rx_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking mon_cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Setup phase and decode of the three mapped words
    wire logic apb_setup  = psel_i && !penable_i;
    wire logic addr_known = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_DATA);

    ////////////////////////////////////////////////////////////
    // Zero-wait answer, one-cycle pulse, error only with ready
    apb_answer_a: assert property (apb_setup |=> pready_o)
        else $error("ready missing after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    err_unmapped_a: assert property (apb_setup && !addr_known |=> pslverr_o)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (apb_setup && addr_known |=> !pslverr_o)
        else $error("mapped access refused");
    err_alone_a: assert property (pslverr_o |-> pready_o)
        else $error("error flag without ready");

    ////////////////////////////////////////////////////////////
    // Pad drive follows the core one cycle later; reset floats pads
    pad_follow_a: assert property (
        !$past(rst_i) |-> pad_out_data_o == $past(core_out_data_i) && pad_tristate_ctl_o == $past(core_tristate_i))
        else $error("pad drive does not follow core");
    reset_state_a: assert property ($past(rst_i) |-> pad_tristate_ctl_o == 2'h3 && !rx_valid_o)
        else $error("outputs not at reset values");
    // Bypass strobe tap and clock tap come from the same synced pad
    strobe_mirror_a: assert property (strobe_delay_in_o == clk_in_path_o[0])
        else $error("strobe tap differs from clock tap");
    // A stalled word must not move or vanish
    rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("word changed while stalled");
endmodule : iocig_monitor

bind iocig_cell_pair iocig_monitor u_monitor (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .core_out_data_i(core_out_data_i),
    .core_tristate_i(core_tristate_i), .pad_out_data_o(pad_out_data_o),
    .pad_tristate_ctl_o(pad_tristate_ctl_o), .clk_in_path_o(clk_in_path_o),
    .strobe_delay_in_o(strobe_delay_in_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_ready_i(rx_ready_i)
);
